/* File: logic/xdm_mapper.sv */
`timescale 1ns/1ps
// Extended data page mapper: turns a 16-bit effective address into a 24-bit one
module xdm_mapper (
   input  wire logic                         core_clk,
   input  wire logic                         nrst,
   // Page register loads from the core
   input  wire logic                         rpage_we,
   input  wire logic [xdm_pkg::RPAGE_W-1:0]  rpage_wdata,
   input  wire logic                         wpage_we,
   input  wire logic [xdm_pkg::WPAGE_W-1:0]  wpage_wdata,
   // Access request from the core's address unit
   input  wire logic                         acc_valid,
   input  wire logic                         acc_write,
   input  wire logic [xdm_pkg::EA_W-1:0]     acc_ea,
   input  wire logic                         repeat_loop,
   // Handshake and mapped result
   output logic                              acc_ready,
   output logic                              out_valid,
   output logic                              out_write,
   output logic                              out_extended,
   output logic [xdm_pkg::PHYS_W-1:0]        out_addr,
   output logic                              addr_error,
   // Current page registers, for the core to read back
   output logic [xdm_pkg::RPAGE_W-1:0]       data_read_page,
   output logic [xdm_pkg::WPAGE_W-1:0]       data_write_page
);
   logic [xdm_pkg::RPAGE_W-1:0] rpage_q;
   logic [xdm_pkg::WPAGE_W-1:0] wpage_q;
   logic [1:0]                  rpt_cnt_q;
   logic                        busy;
   logic                        in_window;
   logic                        take;
   logic                        is_ext_rd;
   logic                        rd_page_bad;
   logic                        wr_page_bad;
   logic [1:0]                  extra;
   logic                        load_stall;
   logic [xdm_pkg::PHYS_W-1:0]  addr_d;
   logic                        addr_err_d;
   // Result registers behind the out_* ports
   logic                        out_valid_q;
   logic                        out_write_q;
   logic                        out_ext_q;
   logic [xdm_pkg::PHYS_W-1:0]  out_addr_q;
   logic                        addr_err_q;

   // Page registers change only on an explicit write; a pointer that wraps
   // inside the window never touches them, software must step the page.
   // An access taken in the same cycle as a load still sees the old page
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rpage_q <= xdm_pkg::RPAGE_RST;
      end else if (rpage_we) begin
         rpage_q <= rpage_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wpage_q <= xdm_pkg::WPAGE_RST;
      end else if (wpage_we) begin
         wpage_q <= wpage_wdata;
      end
   end

   assign data_read_page  = rpage_q;
   assign data_write_page = wpage_q;

   // Window decode: top half of the 16-bit space
   assign in_window = acc_ea[xdm_pkg::WIN_BIT];
   assign take      = acc_valid && acc_ready;
   assign is_ext_rd = take && !acc_write && in_window;

   // Page zero seen through the window is the base memory again: trap it
   assign rd_page_bad = (rpage_q[xdm_pkg::WPAGE_W-1:0] == xdm_pkg::PAGE_ZERO)
                        && !rpage_q[xdm_pkg::RPAGE_HI];
   assign wr_page_bad = (wpage_q == xdm_pkg::PAGE_ZERO);

   // Address build; below the window the page registers are ignored
   always_comb begin
      addr_d = {{(xdm_pkg::PHYS_W-xdm_pkg::EA_W){1'b0}}, acc_ea};
      if (in_window && acc_write) begin
         addr_d = {wpage_q, acc_ea[xdm_pkg::OFS_W-1:0]};
      end else if (in_window) begin
         addr_d = {rpage_q[xdm_pkg::WPAGE_W-1:0], acc_ea[xdm_pkg::OFS_W-1:0]};
      end
   end

   // Trap decode, judged against the page that this direction would use
   always_comb begin
      addr_err_d = 1'b0;
      if (take && in_window && acc_write) begin
         addr_err_d = wr_page_bad;
      end else if (take && in_window) begin
         addr_err_d = rd_page_bad;
      end
   end

   // Result strobe: one cycle per taken access, so a stall never doubles it
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         out_valid_q <= 1'b0;
      end else begin
         out_valid_q <= take;
      end
   end

   // Direction of the access, captured only when it is taken
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         out_write_q <= 1'b0;
      end else if (take) begin
         out_write_q <= acc_write;
      end
   end

   // Window flag for a taken access with effective address bit 15 set
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         out_ext_q <= 1'b0;
      end else begin
         out_ext_q <= take && in_window;
      end
   end

   // Mapped address holds between accesses; reloading only on a take keeps
   // the downstream address lines quiet while the core is stalled
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         out_addr_q <= '0;
      end else if (take) begin
         out_addr_q <= addr_d;
      end
   end

   // Trap pulse stands beside the strobe of the access that caused it
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         addr_err_q <= 1'b0;
      end else begin
         addr_err_q <= addr_err_d;
      end
   end

   // Ports come straight from the result registers
   assign out_valid    = out_valid_q;
   assign out_write    = out_write_q;
   assign out_extended = out_ext_q;
   assign out_addr     = out_addr_q;
   assign addr_error   = addr_err_q;

   // Count extended reads inside one repeat loop; saturates at two
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rpt_cnt_q <= 2'h0;
      end else if (!repeat_loop) begin
         rpt_cnt_q <= 2'h0;
      end else if (is_ext_rd && rpt_cnt_q != xdm_pkg::RPT_SLOW_READS) begin
         rpt_cnt_q <= rpt_cnt_q + 2'h1;
      end
   end

   // Writes never stall; extended reads hold one extra cycle, or two early in a loop.
   // Loop reads past the second run at full speed, so a long table copy
   // pays the overhead only on its first two reads
   always_comb begin
      extra = xdm_pkg::RD_EXTRA;
      if (repeat_loop && rpt_cnt_q < xdm_pkg::RPT_SLOW_READS) begin
         extra = xdm_pkg::RPT_RD_EXTRA;
      end else if (repeat_loop) begin
         extra = 2'h0;
      end
   end

   assign load_stall = is_ext_rd;

   xdm_stall_ctr u_stall (
      .core_clk (core_clk),
      .nrst     (nrst),
      .load     (load_stall),
      .count    (extra),
      .busy     (busy)
   );

   // Ready drops while an extended read is paying its overhead
   assign acc_ready = !busy;
endmodule // xdm_mapper

/* File: logic/xdm_pkg.sv */
// How it works
// - Extended accesses go through the window at the upper half of data space.
// - Extended space is split into 32 Kbyte pages, any mapped into window.
// - Reads use 10-bit read page, writes use 9-bit write page, independently.
// - Window access with page zero raises an address error trap.
// - Read with EA bit 15 set, page bit 9 clear: page low 9 bits above EA low 15.
// - Write with EA bit 15 set: write page low 9 bits above EA low 15.
// - Outside repeat, each extended read costs one extra cycle, two cycles in all.
// - Under repeat, first two extended reads take three cycles, later ones one.
// - Pointer wrap from 0xFFFF to 0x8000 leaves page registers untouched.
// - Addresses below 0x8000 ignore both page registers, go straight to base.
// - Extended writes complete in one cycle with no overhead.
package xdm_pkg;
   localparam int EA_W        = 16;
   localparam int OFS_W       = 15;
   localparam int PHYS_W      = 24;
   localparam int RPAGE_W     = 10;
   localparam int WPAGE_W     = 9;
   localparam int WIN_BIT     = 15;
   localparam int RPAGE_HI    = 9;
   localparam int PAGE_BYTES  = 32768;
   localparam logic [RPAGE_W-1:0] RPAGE_RST = 10'h001;
   localparam logic [WPAGE_W-1:0] WPAGE_RST = 9'h001;
   localparam logic [WPAGE_W-1:0] PAGE_ZERO = 9'h000;
   // Stall cycles: a plain extended read holds one, the first two under repeat hold two
   localparam logic [1:0] RD_EXTRA      = 2'h1;
   localparam logic [1:0] RPT_RD_EXTRA  = 2'h2;
   localparam logic [1:0] RPT_SLOW_READS = 2'h2;

   typedef enum logic [1:0] {
      XDM_IDLE  = 2'b00,
      XDM_STALL = 2'b01
   } xdm_state_t;
endpackage

/* File: logic/xdm_stall_ctr.sv */
`timescale 1ns/1ps
// Down-counter that holds the core for a loaded number of cycles
module xdm_stall_ctr (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       load,
   input  wire logic [1:0] count,
   output logic            busy
);
   logic [1:0] cnt_q;

   // Load wins over counting; a zero load gives no stall
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cnt_q <= 2'h0;
      end else if (load) begin
         cnt_q <= count;
      end else if (cnt_q != 2'h0) begin
         cnt_q <= cnt_q - 2'h1;
      end
   end

   assign busy = (cnt_q != 2'h0);
endmodule // xdm_stall_ctr

/* File: sim/xdm_mapper_assertions.sv */
`timescale 1ns/1ps
// Port-level checker for the mapper; one clock domain, so default clocking is enough
module xdm_chk (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        rpage_we,
   input wire logic        wpage_we,
   input wire logic        acc_valid,
   input wire logic        acc_write,
   input wire logic        repeat_loop,
   input wire logic        acc_ready,
   input wire logic        out_valid,
   input wire logic        out_write,
   input wire logic        out_extended,
   input wire logic        addr_error,
   input wire logic [9:0]  rpage_wdata,
   input wire logic [9:0]  data_read_page,
   input wire logic [8:0]  wpage_wdata,
   input wire logic [8:0]  data_write_page,
   input wire logic [15:0] acc_ea,
   input wire logic [23:0] out_addr
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Taken access and the address parts the mapper is meant to join
   wire        tk  = acc_valid && acc_ready;
   wire [14:0] ofs = acc_ea[14:0];
   wire [8:0]  rp9 = data_read_page[8:0];
   chk_base_map: assert property (tk && !acc_ea[15] |=> out_valid && !out_extended &&
      out_addr == {8'h00, $past(acc_ea)} && !addr_error) else $error("base address wrong");
   chk_win_write: assert property (tk && acc_ea[15] && acc_write |=> out_write &&
      out_valid && out_extended && out_addr == {$past(data_write_page), $past(ofs)})
      else $error("write window wrong");
   chk_win_read: assert property (tk && acc_ea[15] && !acc_write |=> !out_write &&
      out_valid && out_extended && out_addr == {$past(rp9), $past(ofs)})
      else $error("read window wrong");
   chk_zero_trap: assert property (tk && acc_ea[15] && acc_write &&
      data_write_page == 9'h000 |=> addr_error) else $error("page zero not trapped");
   chk_read_stall: assert property (tk && acc_ea[15] && !acc_write && !repeat_loop
      |=> !acc_ready ##1 acc_ready) else $error("read stall not one cycle");
   chk_write_fast: assert property (tk && acc_write |=> acc_ready)
      else $error("write stalled");
   chk_page_load: assert property (rpage_we |=> data_read_page == $past(rpage_wdata))
      else $error("read page not loaded");
   chk_page_hold: assert property (!rpage_we && !wpage_we |=> $stable(data_read_page) &&
      $stable(data_write_page)) else $error("page changed by itself");
   chk_read_trap: assert property (tk && acc_ea[15] && !acc_write &&
      data_read_page == 10'h000 |=> addr_error) else $error("read page zero not trapped");
   chk_no_trap: assert property (tk && acc_ea[15] && rp9 != 9'h000 &&
      data_write_page != 9'h000 |=> !addr_error) else $error("false address trap");
   cover property (tk && acc_ea[15] && !acc_write && data_read_page == 10'h000);
   cover property (tk && acc_ea[15] && !acc_write && repeat_loop);
   cover property (addr_error);
   cover property (tk && acc_ea[15] && acc_write);
endmodule // xdm_chk
bind xdm_mapper xdm_chk xdm_chk_i (.core_clk, .nrst, .rpage_we, .wpage_we, .acc_valid,
   .acc_write, .repeat_loop, .acc_ready, .out_valid, .out_write, .out_extended, .addr_error,
   .rpage_wdata, .data_read_page, .wpage_wdata, .data_write_page, .acc_ea, .out_addr);

/* File: sim/xdm_cpu_model.sv */
`timescale 1ns/1ps
// Core side: holds one access until the mapper takes it, then scrambles the released address
module xdm_cpu_model (
   input  wire logic        core_clk,
   input  wire logic        acc_ready,
   input  wire logic        addr_error,
   input  wire logic [23:0] out_addr,
   output logic             acc_valid,
   output logic             acc_write,
   output logic [15:0]      acc_ea
);
   initial begin
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_ea = 16'h0000;
   end
   // Caller sets bit 15 itself for a window access; n gives stall cycles, -1 if never taken
   task automatic acc(input logic w, input logic [15:0] ea, output int n,
                      output logic [23:0] a, output logic e);
      @(negedge core_clk);
      acc_valid = 1'b1;
      acc_write = w;
      acc_ea = ea;
      n = 0;
      while (acc_ready !== 1'b1 && n < 9) begin @(negedge core_clk); n++; end
      @(posedge core_clk);
      #1 a = out_addr;
      e = addr_error;
      @(negedge core_clk);
      acc_valid = 1'b0;
      acc_ea = ~ea;
      if (n == 9) n = -1;
      else n = 0;
      while (n >= 0 && acc_ready !== 1'b1 && n < 9) begin n++; @(negedge core_clk); end
      if (n >= 9) n = -1;
   endtask
endmodule // xdm_cpu_model

/* File: sim/test_extended_data_page_mapper.sv */
`timescale 1ns/1ps
// Loads pages, issues accesses through the core model and judges the mapped results
module test_extended_data_page_mapper;
   logic             core_clk, nrst, rpage_we, wpage_we, repeat_loop;
   logic [9:0]       rpage_wdata;
   logic [8:0]       wpage_wdata;
   wire logic        acc_valid, acc_write, acc_ready, addr_error;
   wire logic [15:0] acc_ea;
   wire logic [23:0] out_addr;
   wire logic [9:0]  data_read_page;
   wire logic [8:0]  data_write_page;
   int               n_mismatch = 0;
   int               num_checks = 0;
   xdm_mapper xdm_mapper_i (.core_clk, .nrst, .rpage_we, .rpage_wdata, .wpage_we, .wpage_wdata,
      .acc_valid, .acc_write, .acc_ea, .repeat_loop, .acc_ready, .out_valid(), .out_write(),
      .out_extended(), .out_addr, .addr_error, .data_read_page, .data_write_page);
   xdm_cpu_model xdm_cpu_model_i (.core_clk, .acc_ready, .addr_error, .out_addr, .acc_valid,
      .acc_write, .acc_ea);
   initial begin core_clk = 1'b0; forever #5 core_clk = ~core_clk; end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, got, exp); end
   endtask
   task automatic complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One access: address, trap flag and stall count all judged
   task automatic go(input logic w, input logic [15:0] ea, input logic [23:0] ad,
                     input logic er, input int st);
      int n; logic [23:0] a; logic e;
      xdm_cpu_model_i.acc(w, ea, n, a, e);
      if (n < 0) begin
         n_mismatch++;
         $display("BAD %0t access handshake timed out", $time);
         complete_run;
      end else begin
         chk(a, ad);
         chk({23'h0, e}, {23'h0, er});
         chk(24'(n), 24'(st));
      end
   endtask
   task automatic ld(input logic [9:0] r, input logic [8:0] w);
      @(negedge core_clk); rpage_we = 1'b1; wpage_we = 1'b1; rpage_wdata = r; wpage_wdata = w;
      @(negedge core_clk); rpage_we = 1'b0; wpage_we = 1'b0;
      chk({14'h0, data_read_page}, {14'h0, r});
      chk({15'h0, data_write_page}, {15'h0, w});
   endtask
   task automatic t_map; // Independent read and write pages, then a base access
      chk({14'h0, data_read_page}, 24'h000001);
      ld(10'h002, 9'h003);
      go(1'b0, 16'h8800, 24'h010800, 1'b0, 1);
      go(1'b1, 16'h8800, 24'h018800, 1'b0, 0);
      go(1'b0, 16'h1234, 24'h001234, 1'b0, 0);
   endtask
   task automatic t_wrap; // Rollover leaves the write page alone
      go(1'b1, 16'hFFFF, 24'h01FFFF, 1'b0, 0);
      go(1'b1, 16'h8000, 24'h018000, 1'b0, 0);
      chk({15'h0, data_write_page}, 24'h000003);
   endtask
   task automatic t_rpt; // First two reads in a loop stall twice, the third not at all
      ld(10'h004, 9'h004);
      repeat_loop = 1'b1;
      go(1'b0, 16'h8000, 24'h020000, 1'b0, 2);
      go(1'b0, 16'h8002, 24'h020002, 1'b0, 2);
      go(1'b0, 16'h8004, 24'h020004, 1'b0, 0);
      repeat_loop = 1'b0;
   endtask
   task automatic t_trap; // Page zero traps in the window only
      ld(10'h000, 9'h000);
      go(1'b1, 16'hC000, 24'h004000, 1'b1, 0);
      go(1'b0, 16'hC000, 24'h004000, 1'b1, 1);
      go(1'b0, 16'h0010, 24'h000010, 1'b0, 0);
   endtask
   initial begin
      nrst = 1'b0; rpage_we = 1'b0; wpage_we = 1'b0; repeat_loop = 1'b0;
      rpage_wdata = 10'h000; wpage_wdata = 9'h000;
      repeat (8) @(negedge core_clk);
      nrst = 1'b1;
      t_map; t_wrap; t_rpt; t_trap;
      complete_run;
   end
endmodule // test_extended_data_page_mapper
